// *** hw/wdlpm_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the watchdog and low-power block
`ifndef WDLPM_REGS_SVH
`define WDLPM_REGS_SVH
// ------------------------------------------------------------
// Register offsets (word addresses on the plain port)
// ------------------------------------------------------------
`define WDLPM_OFF_POWER_MODE  4'h0
`define WDLPM_OFF_CLOCK_CTL   4'h1
`define WDLPM_OFF_WD_CTL      4'h2
`define WDLPM_OFF_WD_KEY      4'h3
`define WDLPM_OFF_SYS_STATUS  4'h4
`define WDLPM_OFF_COUNTER     4'h5
`define WDLPM_OFF_LP_CMD      4'h6
`define WDLPM_OFF_LP_STATUS   4'h7
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define WDLPM_PMC_PERMIT_BIT  15
`define WDLPM_PMC_QUAL_HI     7
`define WDLPM_PMC_QUAL_LO     2
`define WDLPM_PMC_MODE_HI     1
`define WDLPM_PMC_MODE_LO     0
`define WDLPM_CLK_HALTWAKE    0
`define WDLPM_WDC_FLAG_BIT    7
`define WDLPM_WDC_DISABLE_BIT 6
`define WDLPM_WDC_CHK_HI      5
`define WDLPM_WDC_CHK_LO      3
`define WDLPM_SCS_IRQSTAT_BIT 2
`define WDLPM_SCS_IRQSEL_BIT  1
// ------------------------------------------------------------
// Reset values and key codes
// ------------------------------------------------------------
`define WDLPM_PMC_RESET       16'h00fc
`define WDLPM_QUAL_RESET      6'h3f
`define WDLPM_WATCHDOG_CHECK_BITS_GOOD      3'h5
`define WDLPM_KEY_ARM         8'h55
`define WDLPM_KEY_CLEAR       8'haa
`define WDLPM_CNT_MAX         8'hff
// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define WDLPM_PULSE_CYCLES    10'd512
`define WDLPM_QUAL_EXTRA      7'd2
`endif

// *** hw/wdlpm_pkg.sv ***
// Types used by the watchdog device end; the system end does not import them
package wdlpm_pkg;
   typedef enum logic [1:0] {
      WDLPM_MODE_IDLE    = 2'h0,
      WDLPM_MODE_STANDBY = 2'h1,
      WDLPM_MODE_HALT    = 2'h2
   } wdlpm_mode_e;
   typedef enum logic [1:0] {
      WDLPM_ST_RUN   = 2'h0,
      WDLPM_ST_IDLE  = 2'h1,
      WDLPM_ST_STDBY = 2'h3,
      WDLPM_ST_HALT  = 2'h2
   } wdlpm_state_e;
   typedef logic [15:0] wdlpm_word_t;
endpackage

// *** hw/wdlpm_if.sv ***
// Interface joining the watchdog device end to the system end
`timescale 1ns/1ps
interface wdlpm_if;
   logic                   wdTick;
   logic                   idleExec;
   logic                   wakePinLow;
   logic                   watchdogResetOutN;
   logic                   watchdogIrqOutN;
   logic                   deviceResetPinN;
   logic                   wakeInterrupt;
   logic                   haltWake;
   logic [1:0]             powerState;
   modport device (
      input  wdTick,
      input  idleExec,
      input  wakePinLow,
      output watchdogResetOutN,
      output watchdogIrqOutN,
      output deviceResetPinN,
      output wakeInterrupt,
      output haltWake,
      output powerState
   );
   modport host (
      output wdTick,
      output idleExec,
      output wakePinLow,
      input  watchdogResetOutN,
      input  watchdogIrqOutN,
      input  deviceResetPinN,
      input  wakeInterrupt,
      input  haltWake,
      input  powerState
   );
endinterface

// *** hw/wdlpm_device.sv ***
// Watchdog with key service, pulse outputs and low-power mode control (device end)
`timescale 1ns/1ps
`include "wdlpm_regs.svh"
// Summary of operation
// R1: Mode field 00 idle, 01 standby, 1x halt
// R2: Mode applied only on idle instruction
// R3: Standby wake qualified for field plus two
// R4: Qualification counted only in standby
// R5: Watchdog wakes standby only when permitted
// R6: Software writes zeros to reserved bits
// R7: Halt auto-wake through watchdog reset, flagged
// R8: Standby watchdog wake raises wake interrupt
// R9: Counter maximum gives 512-cycle pulse
// R10: Reset mode drives reset lines, else irq
// R11: Key 0x55 arms, stays armed
// R12: Key 0xAA while armed clears counter
// R13: Other key values disarm
// R14: Key writes never reset the system
// R15: Software services or disables watchdog
// R16: Overflow or bad check bits reset
// R17: Reset flag survives reset, software clears
// R18: Software checks limp status before halt
// R19: High sample restarts qualification
// R20: Irq select picks interrupt over reset
// R21: Counter steps per tick, max 0xff
module wdlpm_device (
   input  wire logic        clk,
   input  wire logic        reset,
   wdlpm_if.device          link,
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdData
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0]                pmc_reg;
   logic                       haltWakeEn_reg;
   logic                       wdDisable_reg;
   logic                       watchdog_reset_flag_reg = 1'b0; // Power-up value only; reset keeps it
   logic                       irqSel_reg;
   logic                       armed_reg;
   logic [7:0]                 cnt_reg;
   logic [9:0]                 pulse_reg;
   logic                       pulseIsReset_reg;
   logic [6:0]                 qual_reg;
   logic [1:0]                 irqStat_reg;
   wdlpm_pkg::wdlpm_state_e    state_reg;
   wdlpm_pkg::wdlpm_state_e    state_next;
   logic                       rstN_reg;
   logic                       irqN_reg;
   logic                       devRstN_reg;
   logic                       wake_reg;
   logic                       haltWake_reg;
   logic [1:0]                 pstate_reg;
   logic [15:0]                rd_reg;
   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction
   wire        wrPmc    = regWrite && hit(regAddr, `WDLPM_OFF_POWER_MODE);
   wire        wrClk    = regWrite && hit(regAddr, `WDLPM_OFF_CLOCK_CTL);
   wire        wrWdc    = regWrite && hit(regAddr, `WDLPM_OFF_WD_CTL);
   wire        wrKey    = regWrite && hit(regAddr, `WDLPM_OFF_WD_KEY);
   wire        wrScs    = regWrite && hit(regAddr, `WDLPM_OFF_SYS_STATUS);
   wire [7:0]  keyVal   = regWrData[7:0];
   wire        keyClear = wrKey && (keyVal == `WDLPM_KEY_CLEAR) && armed_reg; // R12
   // Bad check bits reset the device even with the counter disabled
   wire        badChk   = wrWdc && (regWrData[`WDLPM_WDC_CHK_HI:`WDLPM_WDC_CHK_LO] != `WDLPM_WATCHDOG_CHECK_BITS_GOOD); // R16
   wire        pulseOn  = (pulse_reg != 10'h000);
   wire        halted   = (state_reg == wdlpm_pkg::WDLPM_ST_HALT);
   // Watchdog stops in halt: its oscillator is off
   wire        tickOk   = link.wdTick && !wdDisable_reg && !halted;
   wire        overflow = tickOk && (cnt_reg == `WDLPM_CNT_MAX); // R21
   // Auto-wake from halt forces a watchdog reset
   wire        haltFire = halted && haltWakeEn_reg && link.wdTick; // R7
   wire        fireRst  = ((overflow || haltFire) && !irqSel_reg) || badChk || haltFire; // R16
   wire        fireIrq  = overflow && irqSel_reg && !haltFire; // R20
   // Leaving irq mode while irq pulse active resets at once
   wire        reselect = wrScs && !regWrData[`WDLPM_SCS_IRQSEL_BIT] && irqSel_reg && pulseOn && !pulseIsReset_reg;
   wire        startRst = (fireRst || reselect) && !(pulseOn && pulseIsReset_reg);
   wire        startIrq = fireIrq && !pulseOn;
   wire [1:0]  modeSel  = pmc_reg[`WDLPM_PMC_MODE_HI:`WDLPM_PMC_MODE_LO];
   wire [6:0]  qualLen  = {1'b0, pmc_reg[`WDLPM_PMC_QUAL_HI:`WDLPM_PMC_QUAL_LO]} + `WDLPM_QUAL_EXTRA; // R3
   wire        stdby    = (state_reg == wdlpm_pkg::WDLPM_ST_STDBY);
   wire        qualDone = stdby && link.wakePinLow && (qual_reg + 7'd1 >= qualLen); // R4
   wire        wdWake   = stdby && pmc_reg[`WDLPM_PMC_PERMIT_BIT] && irqSel_reg && startIrq; // R5
   // ------------------------------------------------------------
   // Power-state machine
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         wdlpm_pkg::WDLPM_ST_RUN: begin
            if (link.idleExec) begin // R2
               case (modeSel) // R1
                  2'h0:    state_next = wdlpm_pkg::WDLPM_ST_IDLE;
                  2'h1:    state_next = wdlpm_pkg::WDLPM_ST_STDBY;
                  default: state_next = wdlpm_pkg::WDLPM_ST_HALT;
               endcase
            end
         end
         wdlpm_pkg::WDLPM_ST_IDLE:  if (startIrq) state_next = wdlpm_pkg::WDLPM_ST_RUN;
         wdlpm_pkg::WDLPM_ST_STDBY: if (qualDone || wdWake) state_next = wdlpm_pkg::WDLPM_ST_RUN; // R8
         wdlpm_pkg::WDLPM_ST_HALT:  if (haltFire) state_next = wdlpm_pkg::WDLPM_ST_RUN;
         default:                   state_next = wdlpm_pkg::WDLPM_ST_RUN;
      endcase
      if (startRst) state_next = wdlpm_pkg::WDLPM_ST_RUN;
   end
   // ------------------------------------------------------------
   // Register file; reserved bits dropped on write
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         pmc_reg        <= `WDLPM_PMC_RESET;
         haltWakeEn_reg <= 1'b0;
         wdDisable_reg  <= 1'b0;
         irqSel_reg     <= 1'b0;
      end else begin
         if (wrPmc) pmc_reg <= regWrData & 16'h80ff; // R6
         if (wrClk) haltWakeEn_reg <= regWrData[`WDLPM_CLK_HALTWAKE];
         if (wrWdc) wdDisable_reg <= regWrData[`WDLPM_WDC_DISABLE_BIT];
         if (wrScs) irqSel_reg <= regWrData[`WDLPM_SCS_IRQSEL_BIT];
         if (startRst) irqSel_reg <= 1'b0;
      end
   end
   // Flag is not cleared by reset so it survives the reset it records
   always_ff @(posedge clk) begin
      if (startRst) watchdog_reset_flag_reg <= 1'b1; // R17
      else if (wrWdc && regWrData[`WDLPM_WDC_FLAG_BIT]) watchdog_reset_flag_reg <= 1'b0;
      else if (reset && !rstN_reg) watchdog_reset_flag_reg <= 1'b1;
   end
   // Key sequencer: arm on 0x55, clear on 0xaa, others disarm; never resets
   always_ff @(posedge clk) begin
      if (reset) armed_reg <= 1'b0;
      else if (wrKey) armed_reg <= (keyVal == `WDLPM_KEY_ARM); // R11 R13 R14
   end
   // Counter; overflow wraps to zero
   always_ff @(posedge clk) begin
      if (reset || keyClear || startRst) cnt_reg <= 8'h00; // R12
      else if (tickOk) cnt_reg <= cnt_reg + 8'h01; // R21
   end
   // Pulse timer: 512 cycles low on the selected output
   always_ff @(posedge clk) begin
      if (reset) begin
         pulse_reg        <= 10'h000;
         pulseIsReset_reg <= 1'b0;
      end else if (startRst || startIrq) begin
         pulse_reg        <= `WDLPM_PULSE_CYCLES - 10'd1; // R9
         pulseIsReset_reg <= startRst;
      end else if (pulseOn) begin
         pulse_reg <= pulse_reg - 10'd1;
      end
   end
   // Standby qualification; high sample restarts
   always_ff @(posedge clk) begin
      if (reset || !stdby || !link.wakePinLow) qual_reg <= 7'h00; // R19
      else qual_reg <= qual_reg + 7'd1;
   end
   // Outputs and state, all registered
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg    <= wdlpm_pkg::WDLPM_ST_RUN;
         rstN_reg     <= 1'b1;
         irqN_reg     <= 1'b1;
         devRstN_reg  <= 1'b1;
         wake_reg     <= 1'b0;
         haltWake_reg <= 1'b0;
         pstate_reg   <= 2'h0;
         irqStat_reg  <= 2'h3;
         rd_reg       <= 16'h0000;
      end else begin
         state_reg    <= state_next;
         // Low on the start edge and while the timer runs down to one: 512 cycles in all
         rstN_reg     <= !(startRst || (pulseOn && pulseIsReset_reg)); // R10
         devRstN_reg  <= !(startRst || (pulseOn && pulseIsReset_reg));
         irqN_reg     <= !(startIrq || (pulseOn && !pulseIsReset_reg));
         wake_reg     <= startIrq || qualDone;
         haltWake_reg <= haltFire;
         pstate_reg   <= state_next;
         irqStat_reg  <= {irqStat_reg[0], irqN_reg};
         rd_reg       <= 16'h0000;
         if (regRead) begin
            case (regAddr)
               `WDLPM_OFF_POWER_MODE: rd_reg <= pmc_reg;
               `WDLPM_OFF_CLOCK_CTL:  rd_reg <= {15'h0000, haltWakeEn_reg};
               `WDLPM_OFF_WD_CTL:     rd_reg <= {8'h00, watchdog_reset_flag_reg, wdDisable_reg, 6'h00};
               `WDLPM_OFF_SYS_STATUS: rd_reg <= {13'h0000, irqStat_reg[1], irqSel_reg, 1'b0};
               `WDLPM_OFF_COUNTER:    rd_reg <= {8'h00, cnt_reg};
               `WDLPM_OFF_LP_STATUS:  rd_reg <= {13'h0000, armed_reg, pstate_reg};
               default:               rd_reg <= 16'h0000;
            endcase
         end
      end
   end
   assign regRdData              = rd_reg;
   assign link.watchdogResetOutN = rstN_reg;
   assign link.deviceResetPinN   = devRstN_reg;
   assign link.watchdogIrqOutN   = irqN_reg;
   assign link.wakeInterrupt     = wake_reg;
   assign link.haltWake          = haltWake_reg;
   assign link.powerState        = pstate_reg;
endmodule // wdlpm_device

// *** hw/wdlpm_host.sv ***
// System end: tick source, idle request, wake pin and capture of reset and interrupt events
`timescale 1ns/1ps
`include "wdlpm_regs.svh"
module wdlpm_host (
   input  wire logic        clk,
   input  wire logic        reset,
   wdlpm_if.host            link,
   input  wire logic        tickReq,
   input  wire logic        idleReq,
   input  wire logic        wakeLow,
   output logic             resetSeen,
   output logic             irqSeen,
   output logic             wakeSeen,
   output logic [1:0]       stateOut
);
   // ------------------------------------------------------------
   // Registered drive and capture
   // ------------------------------------------------------------
   logic        tick_reg;
   logic        idle_reg;
   logic        wake_reg;
   logic        irqPrev_reg;
   logic        rstSeen_reg;
   logic        irqSeen_reg;
   logic        wakeSeen_reg;
   logic [1:0]  state_reg;
   // Falling edge of the irq line is the event; level must not retrigger
   wire         irqFall = irqPrev_reg && !link.watchdogIrqOutN;
   // Software checks limp status before halt; not modelled here (R18)
   // Software services the key before overflow or disables (R15)
   always_ff @(posedge clk) begin
      if (reset) begin
         tick_reg     <= 1'b0;
         idle_reg     <= 1'b0;
         wake_reg     <= 1'b0;
         irqPrev_reg  <= 1'b1;
         rstSeen_reg  <= 1'b0;
         irqSeen_reg  <= 1'b0;
         wakeSeen_reg <= 1'b0;
         state_reg    <= 2'h0;
      end else begin
         tick_reg     <= tickReq;
         idle_reg     <= idleReq;
         wake_reg     <= wakeLow;
         irqPrev_reg  <= link.watchdogIrqOutN;
         rstSeen_reg  <= !link.deviceResetPinN;
         irqSeen_reg  <= irqFall;
         wakeSeen_reg <= link.wakeInterrupt;
         state_reg    <= link.powerState;
      end
   end
   assign link.wdTick     = tick_reg;
   assign link.idleExec   = idle_reg;
   assign link.wakePinLow = wake_reg;
   assign resetSeen       = rstSeen_reg;
   assign irqSeen         = irqSeen_reg;
   assign wakeSeen        = wakeSeen_reg;
   assign stateOut        = state_reg;
endmodule // wdlpm_host

// *** tb/wdlpm_properties.sv ***
// Checker for the link between the watchdog device end and the system end
`timescale 1ns/1ps
module wdlpm_properties (
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       wdTick,
   input wire logic       idleExec,
   input wire logic       wakePinLow,
   input wire logic       watchdogResetOutN,
   input wire logic       watchdogIrqOutN,
   input wire logic       deviceResetPinN,
   input wire logic       wakeInterrupt,
   input wire logic       haltWake,
   input wire logic [1:0] powerState
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Low-time counters
   // ----------------------------------------
   logic [10:0] rstLowCnt;
   logic [10:0] irqLowCnt;
   logic [6:0]  pinLowCnt;
   // Pin counter saturates so a long hold cannot wrap
   always_ff @(posedge clk) begin
      rstLowCnt <= (reset || watchdogResetOutN) ? 11'h000 : rstLowCnt + 11'h001;
      irqLowCnt <= (reset || watchdogIrqOutN) ? 11'h000 : irqLowCnt + 11'h001;
      pinLowCnt <= (reset || !wakePinLow) ? 7'h00 : pinLowCnt + {6'h00, pinLowCnt != 7'h7f};
   end
   // ----------------------------------------
   // Sequences and properties
   // ----------------------------------------
   sequence sLeaveRun;
      powerState == 2'h0 ##1 powerState != 2'h0;
   endsequence
   sequence sLeaveStby;
      powerState == 2'h3 ##1 powerState != 2'h3;
   endsequence
   AST_RST_PIN_TIED: assert property (watchdogResetOutN == deviceResetPinN)
      else $error("reset output and reset pin differ");
   AST_RST_PULSE_LEN: assert property ($rose(watchdogResetOutN) |-> rstLowCnt == 11'd512)
      else $error("reset pulse width wrong");
   AST_RST_PULSE_MAX: assert property (rstLowCnt <= 11'd512)
      else $error("reset pulse too long");
   AST_IRQ_PULSE_LEN: assert property ($rose(watchdogIrqOutN) |-> irqLowCnt == 11'd512)
      else $error("irq pulse width wrong");
   AST_IRQ_PULSE_MAX: assert property (irqLowCnt <= 11'd512)
      else $error("irq pulse too long");
   AST_IDLE_ONLY_ENTRY: assert property (sLeaveRun |-> $past(idleExec) || $past(idleExec, 2))
      else $error("power state left run without idle");
   AST_STBY_EXIT_CAUSE: assert property (sLeaveStby |->
      wakeInterrupt || $past(wakeInterrupt) || $past(wakeInterrupt, 2) || !deviceResetPinN)
      else $error("standby left without wake");
   // State has already left standby when the wake pulse shows, so look one cycle back
   AST_PIN_WAKE_QUAL: assert property ((wakeInterrupt && watchdogIrqOutN && $past(powerState) == 2'h3)
      |-> pinLowCnt >= 7'd2)
      else $error("pin wake before qualification");
   AST_IRQ_WAKE_EVENT: assert property ($fell(watchdogIrqOutN) |-> ##[0:2] wakeInterrupt)
      else $error("irq start gave no wake event");
   AST_HALT_WAKE_RESET: assert property (haltWake |-> ##[0:2] !deviceResetPinN)
      else $error("halt wake without watchdog reset");
   AST_HALT_WAKE_SRC: assert property (haltWake |-> powerState == 2'h2 || $past(powerState) == 2'h2)
      else $error("halt wake outside halt");
endmodule // wdlpm_properties

// *** tb/wdlpm_tb_top.sv ***
// Self-checking bench for both ends of the watchdog link
`timescale 1ns/1ps
`include "wdlpm_regs.svh"
module wdlpm_tb_top;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic [3:0]  regAddr = 4'h0;
   logic [15:0] regWrData = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [15:0] regRdData;
   logic        tickReq = 1'b0;
   logic        idleReq = 1'b0;
   logic        wakeLow = 1'b0;
   logic        resetSeen;
   logic        irqSeen;
   logic        wakeSeen;
   int          nWake = 0;
   int          nIrqEv = 0;
   logic [1:0]  stateOut;
   int          mismatches = 0;
   int          nCompared = 0;
   int          cycles = 0;
   wdlpm_if link ();
   wdlpm_device i_wdlpm_device (.clk(clk), .reset(reset), .link(link), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));
   wdlpm_host i_wdlpm_host (.clk(clk), .reset(reset), .link(link), .tickReq(tickReq), .idleReq(idleReq),
      .wakeLow(wakeLow), .resetSeen(resetSeen), .irqSeen(irqSeen), .wakeSeen(wakeSeen), .stateOut(stateOut));
   wdlpm_properties i_wdlpm_properties (.clk(clk), .reset(reset), .wdTick(link.wdTick),
      .idleExec(link.idleExec), .wakePinLow(link.wakePinLow), .watchdogResetOutN(link.watchdogResetOutN),
      .watchdogIrqOutN(link.watchdogIrqOutN), .deviceResetPinN(link.deviceResetPinN),
      .wakeInterrupt(link.wakeInterrupt), .haltWake(link.haltWake), .powerState(link.powerState));
   // 200 MHz clock
   always #2.5 clk = ~clk;
   // Event counts from the host captures
   always @(posedge clk) begin
      nWake <= nWake + int'(wakeSeen);
      nIrqEv <= nIrqEv + int'(irqSeen);
   end
   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         mismatches++;
         stopTest();
      end
   end
   // ----------------------------------------
   // Access and check tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rc(input string what, input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 chk(what, regRdData & mask, exp);
   endtask
   task automatic tick(input int n);
      @(posedge clk);
      tickReq <= 1'b1;
      repeat (n) @(posedge clk);
      tickReq <= 1'b0;
   endtask
   task automatic idle();
      @(posedge clk);
      idleReq <= 1'b1;
      @(posedge clk);
      idleReq <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic hold(input int n);
      @(posedge clk);
      wakeLow <= 1'b1;
      repeat (n) @(posedge clk);
      wakeLow <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   // Measures the low time of the chosen line; sampled mid-cycle, away from the launching edge
   task automatic pulse(input logic irq);
      int n;
      int w;
      n = 0;
      w = 0;
      while ((irq ? link.watchdogIrqOutN : link.watchdogResetOutN) !== 1'b0 && w < 600) begin
         @(negedge clk);
         w++;
      end
      while ((irq ? link.watchdogIrqOutN : link.watchdogResetOutN) === 1'b0 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      chk("pulse cycles", n[15:0], {6'h00, `WDLPM_PULSE_CYCLES});
   endtask
   // Service, step the counter by pre ticks, then give one more tick and watch the pulse
   task automatic fire(input int pre, input logic irq);
      wr(`WDLPM_OFF_WD_KEY, {8'h00, `WDLPM_KEY_ARM});
      wr(`WDLPM_OFF_WD_KEY, {8'h00, `WDLPM_KEY_CLEAR});
      if (pre > 0) tick(pre);
      fork
         tick(1);
         pulse(irq);
      join
   endtask
   task automatic stopTest();
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      logic [7:0] keys [14] = '{8'haa, 8'haa, 8'h55, 8'h55, 8'h55, 8'haa, 8'haa,
                                8'h55, 8'haa, 8'h55, 8'h33, 8'haa, 8'h55, 8'haa};
      int cnt;
      logic armed;
      int m;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rc("mode ctl", `WDLPM_OFF_POWER_MODE, 16'hffff, `WDLPM_PMC_RESET);
      rc("halt wake", `WDLPM_OFF_CLOCK_CTL, 16'h0001, 16'h0000);
      rc("irq select", `WDLPM_OFF_SYS_STATUS, 16'h0006, 16'h0004);
      rc("unmapped", 4'h9, 16'hffff, 16'h0000);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0000);
      $display("test reset values done");
      // Key sequence against a model of arm and clear
      wr(`WDLPM_OFF_WD_CTL, 16'h0028);
      cnt = 0;
      armed = 1'b0;
      foreach (keys[i]) begin
         tick(2);
         cnt += 2;
         wr(`WDLPM_OFF_WD_KEY, {8'h00, keys[i]});
         if (keys[i] == 8'h55) armed = 1'b1;
         else if (keys[i] == 8'haa && armed) cnt = 0;
         if (keys[i] != 8'h55) armed = 1'b0;
         rc("counter", `WDLPM_OFF_COUNTER, 16'h00ff, cnt[15:0]);
         rc("armed", `WDLPM_OFF_LP_STATUS, 16'h0004, {13'h0000, armed, 2'h0});
      end
      chk("no reset", {15'h0000, resetSeen}, 16'h0000);
      wr(`WDLPM_OFF_WD_CTL, 16'h0068);
      tick(3);
      rc("disabled", `WDLPM_OFF_COUNTER, 16'h00ff, cnt[15:0]);
      wr(`WDLPM_OFF_WD_CTL, 16'h0028);
      $display("test key service done");
      fire(255, 1'b0);
      rc("flag", `WDLPM_OFF_WD_CTL, 16'h0080, 16'h0080);
      rc("counter", `WDLPM_OFF_COUNTER, 16'h00ff, 16'h0000);
      fork
         wr(`WDLPM_OFF_WD_CTL, 16'h0000);
         pulse(1'b0);
      join
      wr(`WDLPM_OFF_POWER_MODE, 16'h00fc);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0000);
      idle();
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0001);
      @(posedge clk);
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rc("flag", `WDLPM_OFF_WD_CTL, 16'h0080, 16'h0080);
      wr(`WDLPM_OFF_WD_CTL, 16'h00a8);
      rc("flag", `WDLPM_OFF_WD_CTL, 16'h0080, 16'h0000);
      $display("test reset mode done");
      // Standby left through the watchdog interrupt only when permitted
      wr(`WDLPM_OFF_SYS_STATUS, 16'h0002);
      wr(`WDLPM_OFF_POWER_MODE, 16'h80fd);
      idle();
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0003);
      chk("host state", {14'h0000, stateOut}, 16'h0003);
      fire(255, 1'b1);
      repeat (4) @(posedge clk);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0000);
      chk("no reset", {15'h0000, resetSeen}, 16'h0000);
      wr(`WDLPM_OFF_POWER_MODE, 16'h000d);
      idle();
      fire(255, 1'b1);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0003);
      hold(4);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0003);
      hold(5);
      rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0000);
      chk("wake events", nWake[15:0], 16'h0003);
      chk("irq events", nIrqEv[15:0], 16'h0002);
      $display("test standby done");
      // Both halt codes, left through a watchdog reset
      wr(`WDLPM_OFF_SYS_STATUS, 16'h0000);
      for (m = 2; m < 4; m++) begin
         wr(`WDLPM_OFF_CLOCK_CTL, 16'h0001);
         wr(`WDLPM_OFF_POWER_MODE, {14'h0000, m[1:0]});
         idle();
         rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0002);
         fire(0, 1'b0);
         rc("flag", `WDLPM_OFF_WD_CTL, 16'h0080, 16'h0080);
         rc("state", `WDLPM_OFF_LP_STATUS, 16'h0003, 16'h0000);
         wr(`WDLPM_OFF_WD_CTL, 16'h00a8);
      end
      $display("test halt done");
      stopTest();
   end
endmodule // wdlpm_tb_top
